/* File: hdl/csr_space_pkg.sv */
// constants for the endpoint command and status register space
package csr_space_pkg;

    // ************************************************************
    // configuration port geometry
    // ************************************************************
    localparam int CFG_ADDR_W = 24;
    localparam int NORM_ADDR_W = 35;
    localparam int WORD_LSB = 2;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [23:0] OFF_ADDRESSING_CAPABILITY = 24'h00004C;
    localparam logic [23:0] OFF_CONFIG_WINDOW_HIGH_BASE = 24'h000058;
    localparam logic [23:0] OFF_CONFIG_WINDOW_LOW_BASE = 24'h00005C;
    localparam logic [23:0] OFF_NODE_IDENTIFIER = 24'h000060;
    localparam logic [23:0] OFF_HOST_IDENTIFIER_LOCK = 24'h000068;
    localparam logic [23:0] OFF_COMPONENT_LABEL = 24'h00006C;
    localparam logic [23:0] OFF_SERIAL_PORT_BLOCK = 24'h000100;
    localparam logic [23:0] OFF_SERIAL_LANE_BLOCK = 24'h000400;

    // ************************************************************
    // fixed values and values after reset
    // ************************************************************
    localparam logic [31:0] ADDRESSING_CAPABILITY_VALUE = 32'h00000001;
    localparam logic [31:0] CONFIG_WINDOW_HIGH_BASE_VALUE = 32'h00000000;
    localparam logic [15:0] HOST_NODE_ID_RST = 16'hFFFF;
    localparam logic [31:0] COMPONENT_LABEL_RST = 32'h00000000;
    localparam logic [15:0] CHAIN_END_POINTER = 16'h0000;
    localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int WINDOW_BASE_LSB = 21;
    localparam int WINDOW_BASE_MSB = 30;
    localparam int WINDOW_BASE_W = 10;
    localparam int NORM_MATCH_LSB = 25;
    localparam int NORM_MATCH_MSB = 34;
    localparam int CFG_SPACE_W = 24;
    localparam int SMALL_NODE_ID_LSB = 16;
    localparam int SMALL_NODE_ID_MSB = 23;
    localparam int WIDE_NODE_ID_LSB = 0;
    localparam int WIDE_NODE_ID_MSB = 15;
    localparam int POINTER_LSB = 16;
    localparam int POINTER_MSB = 31;

endpackage

/* File: hdl/reg_write_if.sv */
// register write strobe, data and byte lanes passed to sub-blocks
`timescale 1ns/100ps
interface reg_write_if;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be;
    modport drv (output wr, output wdata, output be);
    modport snk (input wr, input wdata, input be);
endinterface

/* File: hdl/host_id_lock.sv */
// write-once host identifier field with unlock on matching write
`timescale 1ns/100ps
module host_id_lock
    import csr_space_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    reg_write_if.snk wr_port,
    output logic [15:0] host_node_id_o
);

    logic [15:0] id_q;
    logic [15:0] id_d;
    logic unlocked;
    logic both_lanes;
    logic [15:0] lane_merge;

    assign unlocked = (id_q == HOST_NODE_ID_RST);
    assign both_lanes = wr_port.be[0] & wr_port.be[1];
    assign lane_merge = {wr_port.be[1] ? wr_port.wdata[15:8] : id_q[15:8],
                         wr_port.be[0] ? wr_port.wdata[7:0] : id_q[7:0]};

    // a write of all ones simply stores all ones, so the field stays open
    always_comb begin
        id_d = id_q;
        if (wr_port.wr) begin
            if (unlocked) begin
                id_d = lane_merge;
            end else if (both_lanes && wr_port.wdata[15:0] == id_q) begin
                id_d = HOST_NODE_ID_RST;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            id_q <= HOST_NODE_ID_RST;
        end else begin
            id_q <= id_d;
        end
    end

    assign host_node_id_o = id_q;

endmodule

/* File: hdl/window_match.sv */
// compares normal access addresses against the configuration window base
`timescale 1ns/100ps
module window_match
    import csr_space_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [WINDOW_BASE_W-1:0] window_base_i,
    input wire logic norm_req_i,
    input wire logic [NORM_ADDR_W-1:0] norm_addr_i,
    output logic norm_done_o,
    output logic norm_hit_o,
    output logic [CFG_SPACE_W-1:0] norm_cfg_offset_o
);

    logic hit;
    logic done_q;
    logic hit_q;
    logic [CFG_SPACE_W-1:0] offset_q;

    // base is the live register, so a fresh write steers the next compare
    assign hit = norm_req_i &&
                 (norm_addr_i[NORM_MATCH_MSB:NORM_MATCH_LSB] == window_base_i);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
            hit_q <= 1'b0;
            offset_q <= '0;
        end else begin
            done_q <= norm_req_i;
            hit_q <= hit;
            offset_q <= norm_addr_i[CFG_SPACE_W-1:0];
        end
    end

    assign norm_done_o = done_q;
    assign norm_hit_o = hit_q;
    assign norm_cfg_offset_o = offset_q;

endmodule

/* File: hdl/endpoint_csr_space.sv */
// logical-layer command and status registers with extended-features chain
`timescale 1ns/100ps

// Operation
// - addressing capability reads 0x00000001 (34-bit only); writes discarded.
// - high window base reads all zeros; writes discarded.
// - low window base: bits 30..21 writable, all other bits read zero.
// - window base compared with address bits 34..25; hit redirects to config space.
// - window base has build default; a write enabling byte lane 2 or 3 updates it for later compares.
// - node identifier holds 8-bit id at 23..16 and 16-bit id at 15..0.
// - node identifier bits 31..24 read zero; writes there ignored.
// - host lock resets to 0x0000FFFF; first write while all ones stores and locks.
// - when locked, only a write equal to stored value unlocks to all ones.
// - unlock compare needs both low byte lanes in one access.
// - writing all ones to host field leaves it unlocked.
// - component label is 32-bit read-write, resets to zero.
// - serial port block first, serial lane block second at higher offset.
// - each block header holds type code and next pointer; last pointer zero.
// - reserved offsets such as 0x70..0xFC hold no register.
module endpoint_csr_space
    import csr_space_pkg::*;
#(
    parameter logic [WINDOW_BASE_W-1:0] WINDOW_BASE_RST = 10'h000,
    parameter logic [7:0] SMALL_NODE_ID_RST = 8'h00,
    parameter logic [15:0] WIDE_NODE_ID_RST = 16'h0000,
    parameter logic [15:0] SERIAL_PORT_TYPE_CODE = 16'h0001,
    parameter logic [15:0] SERIAL_LANE_TYPE_CODE = 16'h000D
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic cfg_req_i,
    input wire logic cfg_we_i,
    input wire logic [CFG_ADDR_W-1:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic cfg_ack_o,
    output logic [31:0] cfg_rdata_o,
    input wire logic norm_req_i,
    input wire logic [NORM_ADDR_W-1:0] norm_addr_i,
    output logic norm_done_o,
    output logic norm_hit_o,
    output logic [CFG_SPACE_W-1:0] norm_cfg_offset_o,
    output logic [7:0] small_node_id_o,
    output logic [15:0] wide_node_id_o,
    output logic [15:0] host_node_id_o
);

    // ************************************************************
    // address decode
    // ************************************************************
    // the fabric delivers both maintenance and redirected normal accesses here
    wire [CFG_ADDR_W-1:WORD_LSB] word_addr = cfg_addr_i[CFG_ADDR_W-1:WORD_LSB];
    wire sel_cap = (word_addr == OFF_ADDRESSING_CAPABILITY[CFG_ADDR_W-1:WORD_LSB]);
    wire sel_high = (word_addr == OFF_CONFIG_WINDOW_HIGH_BASE[CFG_ADDR_W-1:WORD_LSB]);
    wire sel_low = (word_addr == OFF_CONFIG_WINDOW_LOW_BASE[CFG_ADDR_W-1:WORD_LSB]);
    wire sel_node = (word_addr == OFF_NODE_IDENTIFIER[CFG_ADDR_W-1:WORD_LSB]);
    wire sel_host = (word_addr == OFF_HOST_IDENTIFIER_LOCK[CFG_ADDR_W-1:WORD_LSB]);
    wire sel_label = (word_addr == OFF_COMPONENT_LABEL[CFG_ADDR_W-1:WORD_LSB]);
    wire sel_port_hdr = (word_addr == OFF_SERIAL_PORT_BLOCK[CFG_ADDR_W-1:WORD_LSB]);
    wire sel_lane_hdr = (word_addr == OFF_SERIAL_LANE_BLOCK[CFG_ADDR_W-1:WORD_LSB]);

    wire wr_any = cfg_req_i & cfg_we_i;
    wire wr_low = wr_any & sel_low;
    wire wr_node = wr_any & sel_node;
    wire wr_label = wr_any & sel_label;

    // ************************************************************
    // storage
    // ************************************************************
    logic [WINDOW_BASE_W-1:0] window_base_q;
    logic [7:0] small_id_q;
    logic [15:0] wide_id_q;
    logic [31:0] label_q;
    logic [15:0] host_id;
    logic ack_q;
    logic [31:0] rdata_q;

    // ************************************************************
    // register images as read back
    // ************************************************************
    wire [31:0] img_low = {1'b0, window_base_q, 21'h000000};
    wire [31:0] img_node = {8'h00, small_id_q, wide_id_q};
    wire [31:0] img_host = {16'h0000, host_id};
    // chain is fixed: port block links to lane block, lane block ends it
    wire [31:0] img_port_hdr = {OFF_SERIAL_LANE_BLOCK[15:0], SERIAL_PORT_TYPE_CODE};
    wire [31:0] img_lane_hdr = {CHAIN_END_POINTER, SERIAL_LANE_TYPE_CODE};

    logic [31:0] read_word;

    always_comb begin
        read_word = UNMAPPED_READ_VALUE;
        if (sel_cap) begin
            read_word = ADDRESSING_CAPABILITY_VALUE;
        end else if (sel_high) begin
            read_word = CONFIG_WINDOW_HIGH_BASE_VALUE;
        end else if (sel_low) begin
            read_word = img_low;
        end else if (sel_node) begin
            read_word = img_node;
        end else if (sel_host) begin
            read_word = img_host;
        end else if (sel_label) begin
            read_word = label_q;
        end else if (sel_port_hdr) begin
            read_word = img_port_hdr;
        end else if (sel_lane_hdr) begin
            read_word = img_lane_hdr;
        end
    end

    // ************************************************************
    // byte-lane merge of write data with the addressed register
    // ************************************************************
    // merging against the current image keeps unwritten lanes intact
    wire [31:0] merged;

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign merged[8*b+7:8*b] = cfg_be_i[b] ? cfg_wdata_i[8*b+7:8*b] : read_word[8*b+7:8*b];
        end
    endgenerate

    // ************************************************************
    // writable registers
    // ************************************************************
    // writes to fixed, read-only or unmapped words fall through with no effect
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            window_base_q <= WINDOW_BASE_RST;
        end else if (wr_low) begin
            window_base_q <= merged[WINDOW_BASE_MSB:WINDOW_BASE_LSB];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            small_id_q <= SMALL_NODE_ID_RST;
            wide_id_q <= WIDE_NODE_ID_RST;
        end else if (wr_node) begin
            small_id_q <= merged[SMALL_NODE_ID_MSB:SMALL_NODE_ID_LSB];
            wide_id_q <= merged[WIDE_NODE_ID_MSB:WIDE_NODE_ID_LSB];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            label_q <= COMPONENT_LABEL_RST;
        end else if (wr_label) begin
            label_q <= merged;
        end
    end

    // ************************************************************
    // host identifier lock
    // ************************************************************
    reg_write_if host_wr ();

    assign host_wr.wr = wr_any & sel_host;
    assign host_wr.wdata = cfg_wdata_i;
    assign host_wr.be = cfg_be_i;

    host_id_lock u_host_lock (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .wr_port(host_wr.snk),
        .host_node_id_o(host_id)
    );

    // ************************************************************
    // window compare for normal accesses
    // ************************************************************
    window_match u_window (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .window_base_i(window_base_q),
        .norm_req_i(norm_req_i),
        .norm_addr_i(norm_addr_i),
        .norm_done_o(norm_done_o),
        .norm_hit_o(norm_hit_o),
        .norm_cfg_offset_o(norm_cfg_offset_o)
    );

    // ************************************************************
    // answer path
    // ************************************************************
    // reads and writes both answer one cycle after acceptance; write data
    // returned is the value before the write, so software reads again to confirm
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= cfg_req_i;
            rdata_q <= cfg_req_i ? read_word : 32'h00000000;
        end
    end

    assign cfg_ack_o = ack_q;
    assign cfg_rdata_o = rdata_q;
    assign small_node_id_o = small_id_q;
    assign wide_node_id_o = wide_id_q;
    assign host_node_id_o = host_id;

endmodule

/* File: verification/csr_space_checker.sv */
// port assertions for the command and status register block
`timescale 1ns/100ps
module csr_space_checker
    import csr_space_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic cfg_req_i,
    input wire logic cfg_we_i,
    input wire logic [CFG_ADDR_W-1:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic cfg_ack_o,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic norm_req_i,
    input wire logic norm_done_o,
    input wire logic norm_hit_o,
    input wire logic [7:0] small_node_id_o,
    input wire logic [15:0] wide_node_id_o,
    input wire logic [15:0] host_node_id_o
);
    // ********
    // word decode of the access in flight
    // ********
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire rd = cfg_req_i && !cfg_we_i;
    wire [21:0] wa = cfg_addr_i[23:2];
    wire lk_wr = cfg_req_i && cfg_we_i && wa == 22'h00001A;
    AST_ACK: assert property (cfg_req_i |=> cfg_ack_o)
        else $error("access not answered one cycle later");
    AST_IDLE: assert property (!cfg_req_i |=> !cfg_ack_o && cfg_rdata_o == 32'h00000000)
        else $error("answer or data without an access");
    AST_CAP: assert property (rd && wa == 22'h000013 |=> cfg_rdata_o == 32'h00000001)
        else $error("addressing capability value wrong");
    AST_HIGH: assert property (rd && wa == 22'h000016 |=> cfg_rdata_o == 32'h00000000)
        else $error("high window base not zero");
    AST_LOW: assert property (rd && wa == 22'h000017 |=>
        cfg_rdata_o[31] == 1'b0 && cfg_rdata_o[20:0] == 21'h000000)
        else $error("low window base fixed bits not zero");
    AST_NODE: assert property (rd && wa == 22'h000018 |=>
        cfg_rdata_o == {8'h00, small_node_id_o, wide_node_id_o})
        else $error("node identifier read mismatch");
    AST_HOST: assert property (rd && wa == 22'h00001A |=>
        cfg_rdata_o == {16'h0000, host_node_id_o})
        else $error("host lock read mismatch");
    AST_RSVD: assert property (rd && wa >= 22'h00001C && wa <= 22'h00003F |=>
        cfg_rdata_o == 32'h00000000)
        else $error("reserved word not zero");
    AST_LOCK: assert property (lk_wr && host_node_id_o != 16'hFFFF &&
        cfg_be_i[1:0] != 2'h3 |=> $stable(host_node_id_o))
        else $error("locked host field changed by partial write");
    AST_END: assert property (rd && wa == 22'h000100 |=> cfg_rdata_o[31:16] == 16'h0000)
        else $error("last block pointer not zero");
    AST_DONE: assert property (norm_req_i |=> norm_done_o)
        else $error("address compare not done one cycle later");
    AST_HIT: assert property (norm_hit_o |-> norm_done_o)
        else $error("hit without done");
endmodule

/* File: verification/cfg_fabric_model.sv */
// configuration fabric model: register accesses and window redirects
`timescale 1ns/100ps
module cfg_fabric_model (
    input wire logic sys_clk_i,
    input wire logic ack_i,
    input wire logic [31:0] rdata_i,
    input wire logic done_i,
    input wire logic hit_i,
    input wire logic [23:0] offset_i,
    output logic req_o,
    output logic we_o,
    output logic [23:0] addr_o,
    output logic [3:0] be_o,
    output logic [31:0] wdata_o,
    output logic nreq_o,
    output logic [34:0] naddr_o
);
    initial begin
        {req_o, we_o, addr_o, be_o, wdata_o, nreq_o, naddr_o} = '0;
    end
    // released lines carry the inverse so stale values never look live
    task automatic acc(input logic w, input logic [23:0] a, input logic [3:0] b,
        input logic [31:0] d, output logic [31:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        {req_o, we_o, addr_o, be_o, wdata_o} <= {1'b1, w, a, b, d};
        @(posedge sys_clk_i);
        {req_o, we_o, addr_o, be_o, wdata_o} <= {1'b0, ~w, ~a, ~b, ~d};
        @(negedge sys_clk_i);
        while (ack_i !== 1'b1 && n < 4) begin
            @(negedge sys_clk_i);
            n++;
        end
        ok = (n < 4);
        q = rdata_i;
    endtask
    task automatic nrm(input logic [34:0] a, input logic w, input logic [31:0] d,
        output logic h, output logic [23:0] o, output logic [31:0] q, output logic ok);
        @(posedge sys_clk_i);
        {nreq_o, naddr_o} <= {1'b1, a};
        @(posedge sys_clk_i);
        {nreq_o, naddr_o} <= {1'b0, ~a};
        @(negedge sys_clk_i);
        ok = (done_i === 1'b1);
        h = hit_i;
        o = offset_i;
        q = 32'h00000000;
        if (ok && h === 1'b1) begin
            acc(w, o, 4'hF, d, q, ok);
        end
    endtask
endmodule

/* File: verification/endpoint_csr_space_tb_top.sv */
// self-checking bench for the command and status register block
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR at %0t got %h expected %h", $time, a, e); end end
module endpoint_csr_space_tb_top;
    logic clk, rst, req, we, ack, nreq, done, hit;
    logic [23:0] addr, off;
    logic [3:0] be;
    logic [31:0] wd, rdat;
    logic [34:0] naddr;
    logic [7:0] sid;
    logic [15:0] wid, hid;
    int n_errors = 0;
    int num_checks = 0;
    logic [23:0] ad [11] = '{24'h00004C, 24'h000058, 24'h00005C, 24'h000060, 24'h000068,
        24'h00006C, 24'h000100, 24'h000400, 24'h000064, 24'h0000FC, 24'h800000};
    logic [31:0] ex0 [11] = '{32'h00000001, 32'h0, {1'b0, 10'h2A5, 21'h0}, 32'h005A1234,
        32'h0000FFFF, 32'h0, 32'h04000001, 32'h0000000D, 32'h0, 32'h0, 32'h0};
    logic [31:0] ex1 [11] = '{32'h00000001, 32'h0, 32'h7FE00000, 32'h00FFFFFF,
        32'h0000FFFF, 32'hFFFFFFFF, 32'h04000001, 32'h0000000D, 32'h0, 32'h0, 32'h0};
    endpoint_csr_space #(.WINDOW_BASE_RST(10'h2A5), .SMALL_NODE_ID_RST(8'h5A),
        .WIDE_NODE_ID_RST(16'h1234)) i_endpoint_csr_space (.sys_clk_i(clk), .rst_i(rst),
        .cfg_req_i(req), .cfg_we_i(we), .cfg_addr_i(addr), .cfg_be_i(be),
        .cfg_wdata_i(wd), .cfg_ack_o(ack), .cfg_rdata_o(rdat), .norm_req_i(nreq),
        .norm_addr_i(naddr), .norm_done_o(done), .norm_hit_o(hit),
        .norm_cfg_offset_o(off), .small_node_id_o(sid), .wide_node_id_o(wid),
        .host_node_id_o(hid));
    cfg_fabric_model i_cfg_fabric_model (.sys_clk_i(clk), .ack_i(ack), .rdata_i(rdat),
        .done_i(done), .hit_i(hit), .offset_i(off), .req_o(req), .we_o(we), .addr_o(addr),
        .be_o(be), .wdata_o(wd), .nreq_o(nreq), .naddr_o(naddr));
    // ********
    // access tasks
    // ********
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a lost answer ends the run at once rather than hanging
    task automatic guard(input logic ok);
        `CHK(ok, 1'b1)
        if (ok !== 1'b1) begin
            results();
        end
    endtask
    task automatic wr(input logic [23:0] a, input logic [3:0] b, input logic [31:0] d);
        logic [31:0] q;
        logic ok;
        i_cfg_fabric_model.acc(1'b1, a, b, d, q, ok);
        guard(ok);
    endtask
    task automatic rd(input logic [23:0] a, output logic [31:0] q);
        logic ok;
        i_cfg_fabric_model.acc(1'b0, a, 4'h0, 32'h0, q, ok);
        guard(ok);
    endtask
    task automatic nm(input logic [34:0] a, input logic w, input logic [31:0] d,
        input logic eh, input logic [31:0] eq);
        logic h;
        logic ok;
        logic [23:0] o;
        logic [31:0] q;
        i_cfg_fabric_model.nrm(a, w, d, h, o, q, ok);
        guard(ok);
        `CHK({h, o, q}, {eh, a[23:0], eq})
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        logic [31:0] q;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            rd(ad[i], q);
            `CHK(q, ex0[i])
            wr(ad[i], 4'hF, 32'hFFFFFFFF);
            rd(ad[i], q);
            `CHK(q, ex1[i])
        end
        `CHK({sid, wid}, 24'hFFFFFF)
        wr(24'h000068, 4'hF, 32'h0000ABCD);
        wr(24'h000068, 4'hF, 32'h00001234);
        `CHK(hid, 16'hABCD)
        wr(24'h000068, 4'h1, 32'h0000ABCD);
        `CHK(hid, 16'hABCD)
        wr(24'h000068, 4'h3, 32'h0000ABCD);
        rd(24'h000068, q);
        `CHK(q, 32'h0000FFFF)
        wr(24'h00005C, 4'hF, {1'b0, 10'h155, 21'h0});
        // a write answer carries the value before the write
        nm({10'h155, 25'h000006C}, 1'b1, 32'hCAFEF00D, 1'b1, 32'hFFFFFFFF);
        rd(24'h00006C, q);
        `CHK(q, 32'hCAFEF00D)
        nm({10'h2A5, 25'h000006C}, 1'b0, 32'h0, 1'b0, 32'h0);
        nm({10'h155, 25'h000005C}, 1'b1, {1'b0, 10'h0F0, 21'h0}, 1'b1, {1'b0, 10'h155, 21'h0});
        nm({10'h155, 25'h000004C}, 1'b0, 32'h0, 1'b0, 32'h0);
        nm({10'h0F0, 25'h000004C}, 1'b0, 32'h0, 1'b1, 32'h00000001);
        results();
    end
endmodule
bind endpoint_csr_space csr_space_checker i_csr_space_checker (.sys_clk_i, .rst_i,
    .cfg_req_i, .cfg_we_i, .cfg_addr_i, .cfg_be_i, .cfg_ack_o, .cfg_rdata_o, .norm_req_i,
    .norm_done_o, .norm_hit_o, .small_node_id_o, .wide_node_id_o, .host_node_id_o);
